// [dv/modbus_remote_io_poller_tb.sv]
// self-checking bench of the poller: avalon tasks, framer stand-in, integer model
// assumes a one-cycle bus answer and outputs settled three edges after a response
`timescale 1ns/100ps
module modbus_remote_io_poller_tb;
   logic        clk, rst, avs_read, avs_write, ok_i, irq, txn_valid, txn_ready, txn_write, rsp_valid, rsp_ok;
   logic        avs_waitrequest, a1, a2;
   logic [7:0]  avs_address, txn_slave;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable, delay_i;
   logic [1:0]  txn_kind, remote_output_state, remote_binary_input;
   logic [1:0]  analog_alarm_stage_one_signal, analog_alarm_stage_two_signal;
   logic [13:0] txn_reg;
   logic [15:0] txn_wdata, rsp_data, data_i;
   logic [63:0] remote_analog_input;
   logic [5:0]  analog_unit;
   int          mismatches, checks_done, cyc, seed, y, r, n, nf[2];
   int          raws[6] = '{500, 420, 350, 800, 700, 100};

   mrp_poller uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .irq, .txn_valid, .txn_ready, .txn_write, .txn_kind, .txn_slave,
      .txn_reg, .txn_wdata, .rsp_valid, .rsp_ok, .rsp_data, .remote_output_state, .remote_analog_input,
      .analog_unit, .remote_binary_input, .analog_alarm_stage_one_signal, .analog_alarm_stage_two_signal);
   mrp_framer_model partner (.clk, .rst, .txn_valid, .ok_i, .data_i, .delay_i, .txn_ready, .rsp_valid,
      .rsp_ok, .rsp_data);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   // holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) mismatches++;
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, e, q);
   endtask : rdchk

   // two pulses, since the first may still carry the previous stimulus
   task automatic wait_rsp();
      int k;
      k = 0;
      repeat (2) do begin
         @(posedge clk);
         k++;
      end while (rsp_valid !== 1'b1 && k < 3000);
      if (k >= 3000) mismatches++;
      repeat (3) @(posedge clk);
   endtask : wait_rsp

   always @(posedge clk) begin
      cyc++;
      if (rsp_valid === 1'b1 && rsp_ok === 1'b0) nf[txn_write ? 1 : 0]++;
      if (cyc == 30000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      seed = 74544;
      {avs_read, avs_write, avs_address, avs_writedata, data_i, delay_i, remote_output_state} = '0;
      rst = 1'b1;
      ok_i = 1'b1;
      avs_byteenable = 4'hf;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdchk("cfg0", 8'h40, 32'h6);
      rdchk("cfg2", 8'h80, 32'h40);
      rdchk("addr0", 8'h44, 32'h0001_0001);
      rdchk("unmapped", 8'h24, 32'h0);
      bus(1'b1, 8'h08, 32'h10);
      bus(1'b1, 8'h0c, 32'h32);
      bus(1'b1, 8'h44, {2'h0, 14'h270f, 8'h00, 8'hf7});
      bus(1'b1, 8'h48, 32'h64);
      bus(1'b1, 8'h4c, 32'h03e8_0000);
      bus(1'b1, 8'h50, 32'h03b6_ffce);
      bus(1'b1, 8'h54, 32'h12c);
      bus(1'b1, 8'h58, 32'h258);
      {a1, a2} = 2'h0;
      for (int i = 0; i < 6; i++) begin
         r = raws[i] + ($random(seed) & 3);
         data_i <= 16'(r);
         delay_i <= 4'($random(seed));
         bus(1'b1, 8'h40, 32'h7 | (i << 3));
         wait_rsp();
         y = -50 + (r - 100) * 1000 / 1000;
         a1 = y > 300 ? 1'b1 : y < 250 ? 1'b0 : a1;
         a2 = y > 600 ? 1'b1 : y < 550 ? 1'b0 : a2;
         chk("value0", y, remote_analog_input[31:0]);
         chk("unit0", i, {26'h0, analog_unit});
         chk("alarms", {a2, a1}, {analog_alarm_stage_two_signal[0], analog_alarm_stage_one_signal[0]});
         chk("target", {8'hf7, 14'h270f, 2'h3}, {txn_slave, txn_reg, txn_kind});
         rdchk("value_reg", 8'h10, y);
      end
      rdchk("irq_stat", 8'h00, 32'h5);
      chk("irq_masked", 32'h0, irq);
      $display("analog test done");
      bus(1'b1, 8'h40, 32'h6);
      for (int k = 0; k < 4; k++) begin
         n = ($random(seed) & 15) + 1;
         data_i <= 16'($random(seed));
         bus(1'b1, 8'h80, 32'h1 | (k << 1) | (n << 6));
         wait_rsp();
         chk("bin", data_i[n-1], remote_binary_input[0]);
         chk("bin_kind", k, txn_kind);
      end
      $display("binary test done");
      remote_output_state <= 2'($random(seed));
      bus(1'b1, 8'h80, 32'h40);
      bus(1'b1, 8'hc0, 32'h1);
      wait_rsp();
      chk("out_txn", {1'b1, 15'h0, remote_output_state[0]}, {txn_write, txn_wdata});
      $display("output test done");
      bus(1'b1, 8'h80, 32'h41);
      nf = '{0, 0};
      ok_i <= 1'b0;
      repeat (3) wait_rsp();
      bus(1'b1, 8'hc0, 32'h0);
      bus(1'b1, 8'h80, 32'h40);
      // lets any request in flight finish before the counters are read
      repeat (40) @(posedge clk);
      bus(1'b0, 8'h9c, 32'h0);
      chk("err_in", nf[0], q[15:0]);
      bus(1'b0, 8'hdc, 32'h0);
      chk("err_out", nf[1], q[15:0]);
      chk("irq_on", 32'h1, irq);
      bus(1'b1, 8'h04, 32'h1f);
      rdchk("irq_clr", 8'h00, 32'h0);
      chk("irq_off", 32'h0, irq);
      chk("held", y, remote_analog_input[31:0]);
      chk("idle_outs", 32'h0, remote_analog_input[63:32] | {analog_alarm_stage_two_signal[1],
          analog_alarm_stage_one_signal[1], remote_binary_input[1]});
      $display("error and irq test done");
      summarize();
   end
endmodule : modbus_remote_io_poller_tb

// [dv/mrp_framer_model.sv]
// serial framer stand-in: takes one request, answers after a delay
// assumes the poller's txn/rsp handshake on the same clock
`timescale 1ns/100ps
module mrp_framer_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        txn_valid,
   input  wire logic        ok_i,
   input  wire logic [15:0] data_i,
   input  wire logic [3:0]  delay_i,
   output logic             txn_ready,
   output logic             rsp_valid,
   output logic             rsp_ok,
   output logic [15:0]      rsp_data
);
   logic       busy;
   logic [3:0] cnt;
   // answer lines toggle outside the pulse so no stale word looks valid
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {txn_ready, rsp_valid, rsp_ok, rsp_data, busy, cnt} <= '0;
      end else begin
         rsp_valid <= 1'b0;
         rsp_ok    <= ~rsp_ok;
         rsp_data  <= ~rsp_data;
         if (txn_valid && !txn_ready && !busy) begin
            txn_ready <= 1'b1;
         end else if (txn_ready) begin
            txn_ready <= 1'b0;
            busy      <= 1'b1;
            cnt       <= delay_i;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy      <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_ok    <= ok_i;
            rsp_data  <= data_i;
         end
      end
   end
endmodule : mrp_framer_model

// [rtl/mrp_alarm.sv]
// one alarm stage with hysteresis on release
// assumes upd pulses once per fresh scaled value
`timescale 1ns/100ps
module mrp_alarm
   import mrp_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               upd,
   input  wire logic signed [31:0] value,
   input  wire logic signed [31:0] limit,
   input  wire logic [13:0]        hyst,
   output logic                    alarm
);
   logic signed [33:0] rel_lo;

   assign rel_lo = 34'(limit) - 34'($signed({1'b0, hyst}));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm <= 1'b0;
      end else if (upd) begin
         if (value > limit) begin
            alarm <= 1'b1;
         end else if (34'(value) < rel_lo) begin
            alarm <= 1'b0;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   alarm_raise_a: assert property (upd && value > limit |=> alarm)
      else $error("alarm not raised above limit");
   alarm_hyst_a: assert property (alarm && upd && 34'(value) >= rel_lo |=> alarm)
      else $error("alarm left inside hysteresis band");
   alarm_hold_a: assert property (!upd |=> $stable(alarm))
      else $error("alarm moved without new value");
endmodule : mrp_alarm

// [rtl/mrp_cfg_cfg.svh]
// offsets, field positions, reset values and timing counts of the remote i/o poller
// assumes inclusion by every poller file; byte addresses on an 8-bit avalon address
`ifndef MRP_CFG_CFG_SVH
`define MRP_CFG_CFG_SVH
`define MRP_CLK_MHZ     10
`define MRP_TIMEOUT_US  100
`define MRP_TIMEOUT_CYC (`MRP_TIMEOUT_US * `MRP_CLK_MHZ)
`define MRP_N_CH        6
`define MRP_N_ANA       2
`define MRP_BIN_FIRST   3'h2
`define MRP_OUT_FIRST   3'h4
// global registers
`define MRP_IRQ_STAT    3'h0
`define MRP_IRQ_CLR     3'h1
`define MRP_IRQ_EN      3'h2
`define MRP_HYST        3'h3
`define MRP_VALUE0      3'h4
`define MRP_VALUE1      3'h5
// channel c sits at 8'h40 + 8'h20 * c, word index below
`define MRP_CH_BASE_HI  3'h2
`define MRP_F_CFG       3'h0
`define MRP_F_ADDR      3'h1
`define MRP_F_OFFS      3'h2
`define MRP_F_XPTS      3'h3
`define MRP_F_YPTS      3'h4
`define MRP_F_LIM1      3'h5
`define MRP_F_LIM2      3'h6
`define MRP_F_CHST      3'h7
// channel cfg and addr fields
`define MRP_CFG_EN      0
`define MRP_CFG_KIND    1
`define MRP_CFG_UNIT    3
`define MRP_CFG_SEL     6
`define MRP_ADR_SLV     0
`define MRP_ADR_REG     16
`define MRP_SLV_MIN     8'h01
`define MRP_SLV_MAX     8'hf7
`define MRP_REG_MIN     14'h0001
`define MRP_REG_MAX     14'h270f
`define MRP_SEL_MIN     5'h01
`define MRP_SEL_MAX     5'h10
// interrupt status bits
`define MRP_EV_A1       0
`define MRP_EV_A2       2
`define MRP_EV_ERR      4
`define MRP_EV_W        5
// reset values
`define MRP_CFG_RST_ANA 32'h0000_0006
`define MRP_CFG_RST_BIN 32'h0000_0040
`define MRP_CFG_RST_OUT 32'h0000_0000
`define MRP_ADDR_RST    32'h0001_0001
`define MRP_HYST_RST    14'h0000
`endif

// [rtl/mrp_pkg.sv]
// types of the remote i/o poller
// assumes mrp_cfg_cfg.svh for the numeric constants
package mrp_pkg;
   typedef enum logic [3:0] {
      MRP_IDLE = 4'h1,
      MRP_SEND = 4'h2,
      MRP_WAIT = 4'h4,
      MRP_UPD  = 4'h8
   } mrp_state_t;
   typedef enum logic [1:0] {
      MRP_COIL_STATUS    = 2'h0,
      MRP_DISCRETE_INPUT = 2'h1,
      MRP_INPUT_REGISTER = 2'h2,
      MRP_HOLDING_REG    = 2'h3
   } mrp_kind_t;
   typedef enum logic [2:0] {
      MRP_UNIT_C   = 3'h0,
      MRP_UNIT_F   = 3'h1,
      MRP_UNIT_K   = 3'h2,
      MRP_UNIT_MA  = 3'h3,
      MRP_UNIT_OHM = 3'h4,
      MRP_UNIT_VA  = 3'h5
   } mrp_unit_t;
endpackage : mrp_pkg

// [rtl/mrp_poller.sv]
// remote i/o poller: avalon-mm register slave, channel sequencer, scaling, alarms
// assumes a serial framer on the expansion port takes txn_* requests and answers
// with one rsp_valid pulse; all inputs synchronous to clk
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "mrp_cfg_cfg.svh"
module mrp_poller
   import mrp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   output logic             txn_valid,
   input  wire logic        txn_ready,
   output logic             txn_write,
   output logic [1:0]       txn_kind,
   output logic [7:0]       txn_slave,
   output logic [13:0]      txn_reg,
   output logic [15:0]      txn_wdata,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_ok,
   input  wire logic [15:0] rsp_data,
   input  wire logic [1:0]  remote_output_state,
   output logic [63:0]      remote_analog_input,
   output logic [5:0]       analog_unit,
   output logic [1:0]       remote_binary_input,
   output logic [1:0]       analog_alarm_stage_one_signal,
   output logic [1:0]       analog_alarm_stage_two_signal
);
   localparam int TMO_C = `MRP_TIMEOUT_CYC;

   mrp_state_t         st_q;
   logic [2:0]         ch_q;
   logic [15:0]        tmr_q;
   logic [15:0]        raw_q;
   logic               ok_q;
   logic [31:0]        cfg_q [`MRP_N_CH];
   logic [31:0]        addr_q [`MRP_N_CH];
   logic [15:0]        err_q [`MRP_N_CH];
   logic [31:0]        offs_q [`MRP_N_ANA];
   logic [31:0]        xpts_q [`MRP_N_ANA];
   logic [31:0]        ypts_q [`MRP_N_ANA];
   logic [31:0]        lim1_q [`MRP_N_ANA];
   logic [31:0]        lim2_q [`MRP_N_ANA];
   logic signed [31:0] scaled [`MRP_N_ANA];
   logic [13:0]        hyst_q;
   logic [`MRP_EV_W-1:0] irq_stat_q;
   logic [`MRP_EV_W-1:0] irq_en_q;
   logic [`MRP_EV_W-1:0] next_irq_stat;
   logic [`MRP_EV_W-1:0] ev;
   logic [3:0]         al_prev_q;
   logic [1:0]         upd_ana;
   logic               upd;
   logic               wen;
   logic               a_is_ch;
   logic [2:0]         a_ch;
   logic [2:0]         a_fld;
   logic [31:0]        rd_word;
   logic [4:0]         sel_cur;
   logic [15:0]        err_cur;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // a channel is polled only when enabled and its slave, register, analog kind and binary bit select are in range
   function automatic logic ch_ok(input logic [31:0] c,
                                  input logic [31:0] a,
                                  input logic [2:0]  n);
      logic [7:0]  s;
      logic [13:0] r;
      logic [4:0]  b;
      logic        k;
      s = a[`MRP_ADR_SLV +: 8];
      r = a[`MRP_ADR_REG +: 14];
      b = c[`MRP_CFG_SEL +: 5];
      k = (n < `MRP_BIN_FIRST) ? c[`MRP_CFG_KIND + 1] : 1'b1;
      if (n >= `MRP_BIN_FIRST && n < `MRP_OUT_FIRST) begin
         k = k && b >= `MRP_SEL_MIN && b <= `MRP_SEL_MAX;
      end
      return c[`MRP_CFG_EN] && k
             && s >= `MRP_SLV_MIN && s <= `MRP_SLV_MAX
             && r >= `MRP_REG_MIN && r <= `MRP_REG_MAX;
   endfunction : ch_ok

   function automatic logic [2:0] nxt_ch(input logic [2:0] n);
      return (n == 3'(`MRP_N_CH - 1)) ? 3'h0 : 3'(n + 3'h1);
   endfunction : nxt_ch

   // avalon slave: every access answered one cycle after it is seen
   assign wen     = avs_write && !avs_waitrequest;
   assign a_is_ch = avs_address[7:5] >= `MRP_CH_BASE_HI;
   assign a_ch    = 3'(avs_address[7:5] - `MRP_CH_BASE_HI);
   assign a_fld   = avs_address[4:2];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= rd_word;
      end
   end

   always_comb begin
      rd_word = 32'h0;
      if (a_is_ch) begin
         case (a_fld)
            `MRP_F_CFG:  rd_word = cfg_q[a_ch];
            `MRP_F_ADDR: rd_word = addr_q[a_ch];
            `MRP_F_CHST: rd_word = {13'h0,
                                    a_ch < `MRP_BIN_FIRST && analog_alarm_stage_two_signal[a_ch[0]],
                                    a_ch < `MRP_BIN_FIRST && analog_alarm_stage_one_signal[a_ch[0]],
                                    a_ch >= `MRP_OUT_FIRST ? remote_output_state[a_ch[0]]
                                    : a_ch >= `MRP_BIN_FIRST && remote_binary_input[a_ch[0]],
                                    err_q[a_ch]};
            default: begin
               if (a_ch < `MRP_BIN_FIRST) begin
                  case (a_fld)
                     `MRP_F_OFFS: rd_word = {16'h0, offs_q[a_ch[0]][15:0]};
                     `MRP_F_XPTS: rd_word = xpts_q[a_ch[0]];
                     `MRP_F_YPTS: rd_word = ypts_q[a_ch[0]];
                     `MRP_F_LIM1: rd_word = lim1_q[a_ch[0]];
                     `MRP_F_LIM2: rd_word = lim2_q[a_ch[0]];
                     default:     rd_word = 32'h0;
                  endcase
               end
            end
         endcase
      end else if (avs_address[7:5] == 3'h0) begin
         case (a_fld)
            `MRP_IRQ_STAT: rd_word = 32'(irq_stat_q);
            `MRP_IRQ_EN:   rd_word = 32'(irq_en_q);
            `MRP_HYST:     rd_word = 32'(hyst_q);
            `MRP_VALUE0:   rd_word = remote_analog_input[31:0];
            `MRP_VALUE1:   rd_word = remote_analog_input[63:32];
            default:       rd_word = 32'h0;
         endcase
      end
   end

   // per-channel settings
   for (genvar i = 0; i < `MRP_N_CH; i++) begin : g_ch
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            cfg_q[i]  <= (i < 2) ? `MRP_CFG_RST_ANA : (i < 4) ? `MRP_CFG_RST_BIN : `MRP_CFG_RST_OUT;
            addr_q[i] <= `MRP_ADDR_RST;
         end else if (wen && a_is_ch && a_ch == 3'(i)) begin
            if (a_fld == `MRP_F_CFG) begin
               cfg_q[i] <= be_merge(cfg_q[i], avs_writedata, avs_byteenable);
            end
            if (a_fld == `MRP_F_ADDR) begin
               addr_q[i] <= be_merge(addr_q[i], avs_writedata, avs_byteenable);
            end
         end
      end

      // failed or timed-out transaction counts, saturating
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            err_q[i] <= 16'h0;
         end else if (upd && !ok_q && ch_q == 3'(i) && err_q[i] != 16'hffff) begin
            err_q[i] <= err_q[i] + 16'h1;
         end
      end
   end

   // analog settings, scaling and alarm stages
   for (genvar i = 0; i < `MRP_N_ANA; i++) begin : g_ana
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            offs_q[i] <= 32'h0;
            xpts_q[i] <= 32'h0;
            ypts_q[i] <= 32'h0;
            lim1_q[i] <= 32'h0;
            lim2_q[i] <= 32'h0;
         end else if (wen && a_is_ch && a_ch == 3'(i)) begin
            case (a_fld)
               `MRP_F_OFFS: offs_q[i] <= be_merge(offs_q[i], avs_writedata, avs_byteenable);
               `MRP_F_XPTS: xpts_q[i] <= be_merge(xpts_q[i], avs_writedata, avs_byteenable);
               `MRP_F_YPTS: ypts_q[i] <= be_merge(ypts_q[i], avs_writedata, avs_byteenable);
               `MRP_F_LIM1: lim1_q[i] <= be_merge(lim1_q[i], avs_writedata, avs_byteenable);
               `MRP_F_LIM2: lim2_q[i] <= be_merge(lim2_q[i], avs_writedata, avs_byteenable);
               default: ;
            endcase
         end
      end

      // a channel disabled while its request is in flight keeps its old value
      assign upd_ana[i] = upd && ok_q && ch_q == 3'(i) && ch_ok(cfg_q[i], addr_q[i], 3'(i));

      mrp_scale u_scale (
         .raw    (raw_q),
         .offset (offs_q[i][15:0]),
         .x1     (xpts_q[i][15:0]),
         .x2     (xpts_q[i][31:16]),
         .y1     (ypts_q[i][15:0]),
         .y2     (ypts_q[i][31:16]),
         .scaled (scaled[i])
      );

      mrp_alarm u_al1 (
         .clk   (clk),
         .rst   (rst),
         .upd   (upd_ana[i]),
         .value (scaled[i]),
         .limit (lim1_q[i]),
         .hyst  (hyst_q),
         .alarm (analog_alarm_stage_one_signal[i])
      );

      mrp_alarm u_al2 (
         .clk   (clk),
         .rst   (rst),
         .upd   (upd_ana[i]),
         .value (scaled[i]),
         .limit (lim2_q[i]),
         .hyst  (hyst_q),
         .alarm (analog_alarm_stage_two_signal[i])
      );
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hyst_q <= `MRP_HYST_RST;
      end else if (wen && !a_is_ch && avs_address[7:5] == 3'h0 && a_fld == `MRP_HYST) begin
         hyst_q <= avs_writedata[13:0];
      end
   end

   // poll sequencer: one request per enabled channel, then the next
   assign upd = (st_q == MRP_UPD);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= MRP_IDLE;
         ch_q <= 3'h0;
      end else begin
         case (st_q)
            MRP_IDLE: begin
               if (ch_ok(cfg_q[ch_q], addr_q[ch_q], ch_q)) begin
                  st_q <= MRP_SEND;
               end else begin
                  ch_q <= nxt_ch(ch_q);
               end
            end
            MRP_SEND: begin
               if (txn_ready) begin
                  st_q <= MRP_WAIT;
               end
            end
            MRP_WAIT: begin
               if (rsp_valid || tmr_q == 16'(TMO_C - 1)) begin
                  st_q <= MRP_UPD;
               end
            end
            MRP_UPD: begin
               st_q <= MRP_IDLE;
               ch_q <= nxt_ch(ch_q);
            end
            default: begin
               st_q <= MRP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txn_valid <= 1'b0;
         txn_write <= 1'b0;
         txn_kind  <= 2'h0;
         txn_slave <= 8'h0;
         txn_reg   <= 14'h0;
         txn_wdata <= 16'h0;
      end else if (st_q == MRP_IDLE && ch_ok(cfg_q[ch_q], addr_q[ch_q], ch_q)) begin
         txn_valid <= 1'b1;
         txn_slave <= addr_q[ch_q][`MRP_ADR_SLV +: 8];
         txn_reg   <= addr_q[ch_q][`MRP_ADR_REG +: 14];
         if (ch_q >= `MRP_OUT_FIRST) begin
            txn_write <= 1'b1;
            txn_kind  <= MRP_COIL_STATUS;
            txn_wdata <= {15'h0, remote_output_state[ch_q[0]]};
         end else begin
            txn_write <= 1'b0;
            txn_kind  <= cfg_q[ch_q][`MRP_CFG_KIND +: 2];
            txn_wdata <= 16'h0;
         end
      end else if (st_q == MRP_SEND && txn_ready) begin
         txn_valid <= 1'b0;
      end
   end

   // answer capture; a silent slave ends the wait as a failure
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmr_q <= 16'h0;
         raw_q <= 16'h0;
         ok_q  <= 1'b0;
      end else if (st_q == MRP_WAIT) begin
         tmr_q <= tmr_q + 16'h1;
         if (rsp_valid) begin
            raw_q <= rsp_data;
            ok_q  <= rsp_ok;
         end else if (tmr_q == 16'(TMO_C - 1)) begin
            ok_q <= 1'b0;
         end
      end else begin
         tmr_q <= 16'h0;
      end
   end

   // scaled results with their unit, binary input bit
   assign sel_cur = 5'(cfg_q[ch_q][`MRP_CFG_SEL +: 5] - 5'h1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remote_analog_input <= 64'h0;
         analog_unit         <= 6'h0;
      end else begin
         for (int k = 0; k < `MRP_N_ANA; k++) begin
            if (upd_ana[k]) begin
               remote_analog_input[k*32 +: 32] <= scaled[k];
               analog_unit[k*3 +: 3] <= cfg_q[k][`MRP_CFG_UNIT +: 3];
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remote_binary_input <= 2'h0;
      end else if (upd && ok_q && ch_q >= `MRP_BIN_FIRST && ch_q < `MRP_OUT_FIRST
                   && ch_ok(cfg_q[ch_q], addr_q[ch_q], ch_q)) begin
         remote_binary_input[ch_q[0]] <= raw_q[sel_cur[3:0]];
      end
   end

   // interrupts: alarm rises and transaction failures; a new event beats a clear
   assign ev = {upd && !ok_q,
                analog_alarm_stage_two_signal & ~al_prev_q[3:2],
                analog_alarm_stage_one_signal & ~al_prev_q[1:0]};

   always_comb begin
      next_irq_stat = irq_stat_q;
      if (wen && avs_address[7:5] == 3'h0 && a_fld == `MRP_IRQ_CLR && avs_byteenable[0]) begin
         next_irq_stat = irq_stat_q & ~avs_writedata[`MRP_EV_W-1:0];
      end
      next_irq_stat = next_irq_stat | ev;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         al_prev_q  <= 4'h0;
         irq_stat_q <= '0;
         irq        <= 1'b0;
      end else begin
         al_prev_q  <= {analog_alarm_stage_two_signal, analog_alarm_stage_one_signal};
         irq_stat_q <= next_irq_stat;
         irq        <= |(irq_stat_q & irq_en_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_en_q <= '0;
      end else if (wen && avs_address[7:5] == 3'h0 && a_fld == `MRP_IRQ_EN && avs_byteenable[0]) begin
         irq_en_q <= avs_writedata[`MRP_EV_W-1:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   assign err_cur = err_q[ch_q];

   sequence s_launch;
      $rose(txn_valid);
   endsequence
   sequence s_fail;
      upd && !ok_q && err_cur != 16'hffff;
   endsequence

   poll_handoff_a: assert property (st_q == MRP_SEND && txn_ready |=> st_q == MRP_WAIT && !txn_valid)
      else $error("request not released after acceptance");
   poll_timeout_a: assert property ($rose(st_q == MRP_WAIT) |-> ##[1:TMO_C] st_q == MRP_UPD)
      else $error("wait outlasted timeout");
   // judged in idle: a disabling write may land on the very edge of a launch
   poll_enabled_a: assert property (st_q == MRP_IDLE && !cfg_q[ch_q][`MRP_CFG_EN] |=> !txn_valid)
      else $error("disabled channel polled");
   slave_range_a: assert property (txn_valid |-> txn_slave inside {[1:247]})
      else $error("slave address out of range");
   reg_range_a: assert property (txn_valid |-> txn_reg inside {[1:9999]})
      else $error("register number out of range");
   ana_kind_a: assert property (s_launch and ch_q < `MRP_BIN_FIRST |-> txn_kind[1])
      else $error("analog channel with bit register type");
   in_errcnt_a: assert property (s_fail and ch_q < `MRP_OUT_FIRST |=> err_q[$past(ch_q)] == $past(err_cur) + 16'h1)
      else $error("input error count not advanced");
   out_errcnt_a: assert property (s_fail and ch_q >= `MRP_OUT_FIRST |=> err_q[$past(ch_q)] == $past(err_cur) + 16'h1)
      else $error("output error count not advanced");
   out_write_a: assert property (s_launch and ch_q >= `MRP_OUT_FIRST
                                 |-> txn_write && txn_wdata[0] == $past(remote_output_state[ch_q[0]]))
      else $error("output state not written");
   unit_tag_a: assert property (upd_ana[0] |=> analog_unit[2:0] == $past(cfg_q[0][`MRP_CFG_UNIT +: 3]))
      else $error("unit not attached to value");
endmodule : mrp_poller

// [rtl/mrp_scale.sv]
// offset correction and two-point scaling of one analog reading
// assumes signed 16-bit raw values and coordinates; purely combinational
`timescale 1ns/100ps
module mrp_scale
   import mrp_pkg::*;
(
   input  wire logic signed [15:0] raw,
   input  wire logic signed [15:0] offset,
   input  wire logic signed [15:0] x1,
   input  wire logic signed [15:0] x2,
   input  wire logic signed [15:0] y1,
   input  wire logic signed [15:0] y2,
   output logic signed [31:0]      scaled
);
   logic signed [17:0] v;
   logic signed [17:0] dx;
   logic signed [17:0] dy;
   logic signed [35:0] num;

   // offset first, then the line through both points
   always_comb begin
      v   = 18'(raw) - 18'(offset);
      dx  = 18'(x2) - 18'(x1);
      dy  = 18'(y2) - 18'(y1);
      num = 36'(v - 18'(x1)) * 36'(dy);
      // equal x points give no slope; hold at point 1 instead of dividing by zero
      if (dx == 18'sh0) begin
         scaled = 32'(y1);
      end else begin
         scaled = 32'(36'(y1) + num / 36'(dx));
      end
   end
endmodule : mrp_scale
